// ===== core/psp_defines.svh
// Purpose: offsets, field positions, reset values and phase codes of the parallel slave byte port
// Assumes: 8-bit register port, one byte per offset
// Notes: definitions only
`ifndef PSP_DEFINES_SVH
`define PSP_DEFINES_SVH

// register offsets
`define OFS_PARALLEL_PORT_DATA 8'h08
`define OFS_STROBE_PORT_PINS 8'h09
`define OFS_PERIPH_IRQ_FLAGS_ONE 8'h0C
`define OFS_DATA_PIN_DIRECTION 8'h88
`define OFS_SLAVE_PORT_CTRL_STAT 8'h89
`define OFS_PERIPH_IRQ_ENABLES_ONE 8'h8C

// slave_port_control_status fields
`define BIT_INPUT_FULL 7
`define BIT_OUTPUT_FULL 6
`define BIT_INPUT_OVERFLOW 5
`define BIT_SLAVE_PORT_ENABLE 4
`define STROBE_DIR_MSB 2

// irq flag / enable field
`define BIT_SLAVE_PORT_IRQ 7

// reset values
`define RST_STROBE_DIR 3'h7
`define RST_DATA_DIR 8'hFF
`define RST_BYTE 8'h00

// four-phase instruction clock codes
`define PHASE_TWO 2'h1
`define PHASE_FOUR 2'h3

`endif

// ===== core/psp_pkg.sv
// Purpose: types shared by the parallel slave byte port
// Assumes: nothing
// Notes: transfer states step one bit at a time from idle to each end state
package psp_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_WRITE = 3'h1,
        ST_WR_END = 3'h3,
        ST_READ = 3'h4,
        ST_RD_END = 3'h6
    } xfer_state_t;

    typedef logic [7:0] byte_t;

endpackage

// ===== core/parallel_slave_byte_port.sv
// Purpose: 8-bit parallel slave port giving an external processor a byte mailbox
// Assumes: clk 100 MHz, rst_n synchronous active low, pins asynchronous to clk
// Notes: a free-running 2-bit counter stands in for the four-phase instruction clock
// clocking and phases
// - one clock domain; every flop updates on each rising edge
// - a 2-bit counter stands in for the four-phase instruction clock
// - phase code 1 plays phase two, phase code 3 plays phase four
// - the counter free-runs from reset, so phase alignment is fixed at release
// - completion timing is quoted against this counter, not against pin edges
//
// pin sampling
// - strobe, select and data pins are asynchronous to clk
// - each passes two flops; only the second stage feeds any logic
// - the first stage is read by nothing else, to keep metastability contained
// - strobes reset to idle high so no false start follows reset
// - data and strobes share the same latency, so a byte and its strobe line up
// - cost: every pin event is seen two cycles late
//
// slave mode gating
// - slave functions need the enable bit and all three strobe directions as input
// - with the enable set but a strobe pin left as output, nothing starts
// - leaving slave mode drops the sequencer back to idle at once
// - a transfer cut by mode off raises no full flag; an end state firing the cycle after mode off still sets slave_port_irq_flag
//
// write path
// - select and write strobe both low start a write from idle
// - write wins when read and write strobes are both low at the start
// - the input latch follows the synced pins for as long as the strobe holds
// - last byte before the release is what firmware later reads
// - a start with input_full_flag still set raises input_overflow_flag
// - the new byte still overwrites the latch; the old one is lost
//
// read path
// - select and read strobe both low start a read from idle
// - output_full_flag drops on the start edge, not on completion
// - data pins are driven one edge after the synced request is seen
// - drive stops one edge after the synced release
// - an external master must not sample before its own sync delay has passed
//
// completion wait
// - a synced release moves the sequencer to its end state
// - the end state waits for a phase two, then fires on the next phase four
// - worst case wait is about seven cycles after the synced release
// - no new transfer starts during the wait; strobes then are missed
// - masters should keep strobes and gaps at least four cycles wide
//
// flags
// - input_full_flag: set by a completed write, cleared by a firmware data read
// - on a tie the hardware set wins, so a byte never looks consumed too early
// - output_full_flag: set by a firmware data write, cleared by a read start
// - on a tie the firmware write wins, so fresh data is always announced
// - input_overflow_flag: set by hardware, cleared by writing zero to its bit
// - writing one to the overflow bit has no effect
// - overflow survives leaving slave mode; full flags are held clear there
// - slave_port_irq_flag: set by any completion, cleared by writing one
// - a completion in the same cycle as the clear keeps the flag set
//
// interrupt output
// - irq is the flag gated by slave_port_irq_enable, registered
// - it follows flag or enable changes one cycle later
// - the flag stays set while masked, so unmasking replays a pending event
//
// register port
// - writes take effect on the edge that samples the strobe
// - read data stand for exactly the one cycle after the strobe
// - read data are zero in every other cycle
// - unmapped offsets accept writes silently and read as zero
// - the shared data offset splits by direction of the access
// - outside slave mode a data read returns the synced pins
//
// general purpose pins
// - data pins follow the data direction register only while the enable bit is clear
// - strobe pins not set as input are driven from the strobe pin latch
// - a one in a direction bit means input, so the pin is not driven
// - output enables are active low and registered with the values
//
// limitations
// - no clock enable; the phase counter runs even when idle
// - a strobe shorter than the sync window may be missed entirely
// - no glitch filter on the strobes beyond the two sync flops
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "psp_defines.svh"

module parallel_slave_byte_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire psp_pkg::byte_t wdata,
    input wire logic wr,
    input wire logic rd,
    output psp_pkg::byte_t rdata,
    output logic irq,
    input wire logic [7:0] data_pin_in,
    output logic [7:0] data_pin_out,
    output logic [7:0] data_pin_oe_n,
    input wire logic [2:0] strobe_pin_in,
    output logic [2:0] strobe_pin_out,
    output logic [2:0] strobe_pin_oe_n
);
    import psp_pkg::*;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // pin synchronisers: first stage read only by the second
    byte_t data_s1_q, data_s2_q;
    logic [2:0] strobe_s1_q, strobe_s2_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_s1_q <= `RST_BYTE;
            data_s2_q <= `RST_BYTE;
            strobe_s1_q <= 3'h7;
            strobe_s2_q <= 3'h7;
        end else begin
            data_s1_q <= data_pin_in;
            data_s2_q <= data_s1_q;
            strobe_s1_q <= strobe_pin_in;
            strobe_s2_q <= strobe_s1_q;
        end
    end

    // four-phase instruction clock
    logic [1:0] phase_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end

    logic q2, q4;
    assign q2 = (phase_q == `PHASE_TWO);
    assign q4 = (phase_q == `PHASE_FOUR);

    // registers
    byte_t out_latch_q, in_latch_q, data_dir_q, strobe_latch_q;
    logic [2:0] strobe_dir_q;
    logic mode_q, ibf_q, obf_q, input_overflow_flag_q, slave_port_irq_flag_q, slave_port_irq_enable_q;

    logic fw_wr_data, fw_rd_data, fw_wr_ctrl, fw_wr_flags;
    assign fw_wr_data = wr && hit(addr, `OFS_PARALLEL_PORT_DATA);
    assign fw_rd_data = rd && hit(addr, `OFS_PARALLEL_PORT_DATA);
    assign fw_wr_ctrl = wr && hit(addr, `OFS_SLAVE_PORT_CTRL_STAT);
    assign fw_wr_flags = wr && hit(addr, `OFS_PERIPH_IRQ_FLAGS_ONE);

    // slave functions live only with mode set and strobe pins as inputs
    logic slave_on;
    assign slave_on = mode_q && (strobe_dir_q == 3'h7);

    // active-low pins, synchronised
    logic sel, wr_req, rd_req;
    assign sel = !strobe_s2_q[2];
    assign wr_req = sel && !strobe_s2_q[1];
    assign rd_req = sel && !strobe_s2_q[0];

    // transfer sequencer
    xfer_state_t state_q;
    logic seen_q2_q;
    logic wr_start, rd_start, end_fire;
    assign wr_start = slave_on && (state_q == ST_IDLE) && wr_req;
    assign rd_start = slave_on && (state_q == ST_IDLE) && !wr_req && rd_req;
    // completion waits for a phase two then fires on the following phase four
    assign end_fire = ((state_q == ST_WR_END) || (state_q == ST_RD_END)) && seen_q2_q && q4;

    always_ff @(posedge clk) begin
        if (!rst_n || !slave_on) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (wr_start) begin
                        state_q <= ST_WRITE;
                    end else if (rd_start) begin
                        state_q <= ST_READ;
                    end
                end
                ST_WRITE: begin
                    if (!wr_req) begin
                        state_q <= ST_WR_END;
                    end
                end
                ST_READ: begin
                    if (!rd_req) begin
                        state_q <= ST_RD_END;
                    end
                end
                ST_WR_END, ST_RD_END: begin
                    if (end_fire) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // phase-two marker for the completion wait
    always_ff @(posedge clk) begin
        if (!rst_n || (state_q != ST_WR_END && state_q != ST_RD_END)) begin
            seen_q2_q <= 1'b0;
        end else if (q2) begin
            seen_q2_q <= 1'b1;
        end
    end

    // input latch follows the pins while the write strobe is held
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            in_latch_q <= `RST_BYTE;
        end else if (wr_start || (state_q == ST_WRITE && wr_req)) begin
            in_latch_q <= data_s2_q;
        end
    end

    // output latch: firmware write side of the shared offset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_latch_q <= `RST_BYTE;
        end else if (fw_wr_data) begin
            out_latch_q <= wdata;
        end
    end

    // input full: hardware set beats a firmware read in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n || !slave_on) begin
            ibf_q <= 1'b0;
        end else if (end_fire && state_q == ST_WR_END) begin
            ibf_q <= 1'b1;
        end else if (fw_rd_data) begin
            ibf_q <= 1'b0;
        end
    end

    // output full: firmware write wins over a read starting alongside
    always_ff @(posedge clk) begin
        if (!rst_n || !slave_on) begin
            obf_q <= 1'b0;
        end else if (fw_wr_data) begin
            obf_q <= 1'b1;
        end else if (rd_start) begin
            obf_q <= 1'b0;
        end
    end

    // overflow survives mode off; firmware clears by writing zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            input_overflow_flag_q <= 1'b0;
        end else if (wr_start && ibf_q) begin
            input_overflow_flag_q <= 1'b1;
        end else if (fw_wr_ctrl && !wdata[`BIT_INPUT_OVERFLOW]) begin
            input_overflow_flag_q <= 1'b0;
        end
    end

    // sticky irq flag, write one to clear, set wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            slave_port_irq_flag_q <= 1'b0;
        end else if (end_fire) begin
            slave_port_irq_flag_q <= 1'b1;
        end else if (fw_wr_flags && wdata[`BIT_SLAVE_PORT_IRQ]) begin
            slave_port_irq_flag_q <= 1'b0;
        end
    end

    // plain control registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_q <= 1'b0;
            strobe_dir_q <= `RST_STROBE_DIR;
            slave_port_irq_enable_q <= 1'b0;
            data_dir_q <= `RST_DATA_DIR;
            strobe_latch_q <= `RST_BYTE;
        end else begin
            if (fw_wr_ctrl) begin
                mode_q <= wdata[`BIT_SLAVE_PORT_ENABLE];
                strobe_dir_q <= wdata[`STROBE_DIR_MSB:0];
            end
            if (wr && hit(addr, `OFS_PERIPH_IRQ_ENABLES_ONE)) begin
                slave_port_irq_enable_q <= wdata[`BIT_SLAVE_PORT_IRQ];
            end
            if (wr && hit(addr, `OFS_DATA_PIN_DIRECTION)) begin
                data_dir_q <= wdata;
            end
            if (wr && hit(addr, `OFS_STROBE_PORT_PINS)) begin
                strobe_latch_q <= wdata;
            end
        end
    end

    // read mux, answered one cycle after the strobe
    byte_t rd_mux;
    always_comb begin
        rd_mux = `RST_BYTE;
        unique case (addr)
            `OFS_PARALLEL_PORT_DATA: rd_mux = slave_on ? in_latch_q : data_s2_q;
            `OFS_STROBE_PORT_PINS: rd_mux = {5'h00, strobe_s2_q};
            `OFS_PERIPH_IRQ_FLAGS_ONE: rd_mux = {slave_port_irq_flag_q, 7'h00};
            `OFS_DATA_PIN_DIRECTION: rd_mux = data_dir_q;
            `OFS_SLAVE_PORT_CTRL_STAT: rd_mux = {ibf_q, obf_q, input_overflow_flag_q, mode_q, 1'b0, strobe_dir_q};
            `OFS_PERIPH_IRQ_ENABLES_ONE: rd_mux = {slave_port_irq_enable_q, 7'h00};
            default: rd_mux = `RST_BYTE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= `RST_BYTE;
        end else if (rd) begin
            rdata <= rd_mux;
        end else begin
            rdata <= `RST_BYTE;
        end
    end

    // interrupt request, masked by the enable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= slave_port_irq_flag_q && slave_port_irq_enable_q;
        end
    end

    // pin drivers; in slave mode direction comes from the strobes, costing sync latency
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_pin_out <= `RST_BYTE;
            data_pin_oe_n <= 8'hFF;
            strobe_pin_out <= 3'h0;
            strobe_pin_oe_n <= 3'h7;
        end else begin
            data_pin_out <= out_latch_q;
            if (mode_q) begin
                data_pin_oe_n <= (slave_on && rd_req && !wr_req) ? 8'h00 : 8'hFF;
            end else begin
                data_pin_oe_n <= data_dir_q;
            end
            strobe_pin_out <= strobe_latch_q[2:0];
            strobe_pin_oe_n <= strobe_dir_q;
        end
    end

endmodule

// ===== dv/psp_host_model.sv
// Purpose: external processor driving the strobe and data pins
// Assumes: strobes held 6 clk, pins settle between transfers
// Notes: released data lines show the inverse of the last byte
`timescale 1ns/1ps
module psp_host_model (
    input wire logic clk,
    input wire logic [7:0] data_pin_out,
    input wire logic [7:0] data_pin_oe_n,
    input wire logic [2:0] strobe_pin_out,
    input wire logic [2:0] strobe_pin_oe_n,
    output logic [7:0] data_pin_in,
    output logic [2:0] strobe_pin_in
);
    logic [2:0] strb_q = 3'h7; // select, write, read all idle high
    logic [7:0] drv_q = 8'h00;
    logic drv_en_q = 1'b0;
    // wire level: device drive wins, else host drive, else a changed pattern
    assign data_pin_in = (~data_pin_oe_n & data_pin_out) | (data_pin_oe_n & (drv_en_q ? drv_q : ~drv_q));
    assign strobe_pin_in = (strobe_pin_oe_n & strb_q) | (~strobe_pin_oe_n & strobe_pin_out);
    // select and write low together, data held for the strobe
    task automatic ext_write(input logic [7:0] d);
        @(posedge clk);
        drv_q <= d;
        drv_en_q <= 1'b1;
        strb_q <= 3'h1;
        repeat (6) @(posedge clk);
        strb_q <= 3'h7;
        drv_en_q <= 1'b0;
        repeat (16) @(posedge clk);
    endtask
    // select and read low together, byte taken before release
    task automatic ext_read(output logic [7:0] d);
        @(posedge clk);
        strb_q <= 3'h2;
        repeat (6) @(posedge clk);
        d = data_pin_in;
        strb_q <= 3'h7;
        repeat (16) @(posedge clk);
    endtask
endmodule

// ===== dv/parallel_slave_byte_port_checker.sv
// Purpose: port-level assertions for the parallel slave byte port
// Assumes: data direction register never written by the bench
// Notes: sees only top-level ports
`timescale 1ns/1ps
module parallel_slave_byte_port_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire psp_pkg::byte_t wdata,
    input wire logic wr,
    input wire logic rd,
    input wire psp_pkg::byte_t rdata,
    input wire logic irq,
    input wire logic [7:0] data_pin_oe_n,
    input wire logic [2:0] strobe_pin_in,
    input wire logic [2:0] strobe_pin_oe_n
);
    import psp_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [4:0] hot_q;
    logic [2:0] strb_q;
    logic [7:0] since_q;
    // recent selected reads and cycles since a strobe release
    always_ff @(posedge clk) begin
        hot_q <= {hot_q[3:0], ~strobe_pin_in[2] & ~strobe_pin_in[0]};
        strb_q <= strobe_pin_in;
        if (|(strobe_pin_in & ~strb_q)) begin
            since_q <= 8'h00;
        end else if (since_q != 8'hFF) begin
            since_q <= since_q + 8'h01;
        end
    end
    sequence s_flag_clear;
        wr && addr == 8'h0C && wdata[7];
    endsequence
    sequence s_mask_off;
        wr && addr == 8'h8C && !wdata[7];
    endsequence
    a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 8'h00) else $error("read data outside slot");
    a_oe_all_bits: assert property (data_pin_oe_n == 8'hFF || data_pin_oe_n == 8'h00) else $error("split drive");
    a_drive_needs_read: assert property (data_pin_oe_n == 8'h00 |-> |hot_q) else $error("drive without read");
    a_dir_gates_drive: assert property (strobe_pin_oe_n != 3'h7 |-> data_pin_oe_n == 8'hFF) else $error("drive off mode");
    a_irq_after_release: assert property ($rose(irq) |-> (since_q >= 8'd4 && since_q <= 8'd20) || $past(wr, 2))
        else $error("irq not tied to a release");
    a_irq_flag_clear: assert property (s_flag_clear |-> ##2 !irq) else $error("irq kept after clear");
    a_irq_mask_off: assert property (s_mask_off |-> ##[1:2] !irq ##1 !irq) else $error("irq not masked");
    a_reset_safe: assert property ($rose(rst_n) |-> strobe_pin_oe_n == 3'h7 && data_pin_oe_n == 8'hFF && !irq)
        else $error("pins driven after reset");
endmodule

// ===== dv/parallel_slave_byte_port_test.sv
// Purpose: self-checking bench for the parallel slave byte port
// Assumes: host model on the pins, firmware via register port
// Notes: one task per scenario
`timescale 1ns/1ps
module parallel_slave_byte_port_test;
    import psp_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    byte_t wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    byte_t rdata;
    logic irq;
    logic [7:0] dp_in, dp_out, dp_oe_n;
    logic [2:0] sp_in, sp_out, sp_oe_n;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [7:0] got;
    always #5 clk = ~clk;
    parallel_slave_byte_port i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .irq(irq), .data_pin_in(dp_in), .data_pin_out(dp_out), .data_pin_oe_n(dp_oe_n),
        .strobe_pin_in(sp_in), .strobe_pin_out(sp_out), .strobe_pin_oe_n(sp_oe_n));
    psp_host_model i_host (.clk(clk), .data_pin_out(dp_out), .data_pin_oe_n(dp_oe_n), .strobe_pin_out(sp_out),
        .strobe_pin_oe_n(sp_oe_n), .data_pin_in(dp_in), .strobe_pin_in(sp_in));
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // reset values and an unmapped offset
    task automatic t_reset_vals;
        reg_rd(8'h89, 8'h07);
        reg_rd(8'h0C, 8'h00);
        reg_rd(8'h8C, 8'h00);
        reg_rd(8'h55, 8'h00);
    endtask
    // host write completes, flags and irq rise, firmware read clears full
    task automatic t_write_path;
        reg_wr(8'h89, 8'h17);
        reg_wr(8'h8C, 8'h80);
        i_host.ext_write(8'hA5);
        reg_rd(8'h89, 8'h97);
        reg_rd(8'h0C, 8'h80);
        chk({7'h00, irq}, 8'h01);
        reg_rd(8'h08, 8'hA5);
        reg_rd(8'h89, 8'h17);
    endtask
    // second write overflows; mode off clears input full but keeps overflow
    task automatic t_overflow;
        i_host.ext_write(8'h3C);
        i_host.ext_write(8'hC3);
        reg_rd(8'h89, 8'hB7);
        reg_wr(8'h89, 8'h27);
        reg_rd(8'h89, 8'h27);
        reg_wr(8'h89, 8'h17);
        reg_rd(8'h89, 8'h17);
        reg_rd(8'h08, 8'hC3);
    endtask
    // firmware fills output latch, host reads it, output full drops
    task automatic t_read_path;
        reg_wr(8'h0C, 8'h80);
        reg_rd(8'h0C, 8'h00);
        reg_wr(8'h08, 8'h5A);
        reg_rd(8'h89, 8'h57);
        i_host.ext_read(got);
        chk(got, 8'h5A);
        reg_rd(8'h89, 8'h17);
        reg_rd(8'h0C, 8'h80);
    endtask
    // masking holds irq low while the flag stays set
    task automatic t_mask;
        reg_wr(8'h8C, 8'h00);
        repeat (2) @(posedge clk);
        chk({7'h00, irq}, 8'h00);
        reg_rd(8'h0C, 8'h80);
        reg_wr(8'h0C, 8'h80);
        reg_rd(8'h0C, 8'h00);
    endtask
    // strobe direction not all input: no transfer, strobe pins stay general purpose, data pins undriven
    task automatic t_mode_gate;
        reg_wr(8'h09, 8'h02);
        reg_wr(8'h89, 8'h13);
        i_host.ext_write(8'h77);
        reg_rd(8'h89, 8'h13);
        chk({5'h00, sp_oe_n}, 8'h03);
        chk({5'h00, sp_out}, 8'h02);
        chk(dp_oe_n, 8'hFF);
        reg_rd(8'h09, 8'h03);
        reg_rd(8'h08, 8'h88);
        reg_rd(8'h0C, 8'h00);
        reg_wr(8'h89, 8'h17);
        reg_rd(8'h89, 8'h17);
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_vals();
        t_write_path();
        t_overflow();
        t_read_path();
        t_mask();
        t_mode_gate();
        test_done();
    end
endmodule
bind parallel_slave_byte_port parallel_slave_byte_port_checker i_chk (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .data_pin_oe_n(data_pin_oe_n),
    .strobe_pin_in(strobe_pin_in), .strobe_pin_oe_n(strobe_pin_oe_n));
